/* rtl/amp_status_pkg.sv */
// =============================================================
// Shared constants of the amplifier status register bank
package amp_status_pkg;

   // =============================================================
   // Channel count and register width
   localparam int NUM_CH  = 4;               // Four amplifier channels
   localparam int REG_W   = 8;               // Width of every register

   // =============================================================
   // Register offsets on the control serial interface
   localparam logic [7:0] OFF_DC_DIAG_B     = 8'h0D;  // DC diagnostic result, ch3/ch4
   localparam logic [7:0] OFF_LINE_OUT      = 8'h0E;  // Line-output detection
   localparam logic [7:0] OFF_CHANNEL_STATE = 8'h0F;  // Per-channel operating state
   localparam logic [7:0] OFF_CHANNEL_FAULT = 8'h10;  // Overcurrent and DC faults
   localparam logic [7:0] OFF_SUPPLY_CLOCK  = 8'h11;  // Supply and clock faults
   localparam logic [7:0] OFF_THERMAL_SD    = 8'h12;  // Thermal shutdowns
   localparam logic [7:0] OFF_WARNINGS      = 8'h13;  // Warnings and power-on flag

   // =============================================================
   // Reset values
   localparam logic [7:0] RST_DC_DIAG_B     = 8'h00;
   localparam logic [7:0] RST_LINE_OUT      = 8'h00;
   localparam logic [7:0] RST_CHANNEL_STATE = 8'h55;
   localparam logic [7:0] RST_CHANNEL_FAULT = 8'h00;
   localparam logic [7:0] RST_WARNINGS      = 8'h20;
   localparam logic [7:0] READ_ZERO         = 8'h00;  // Unmapped offsets read this

   // =============================================================
   // Reserved upper bits, filled with zero on read
   localparam logic [3:0] RSVD4 = 4'h0;     // Bits 7-4 of line-output register
   localparam logic [2:0] RSVD3 = 3'h0;     // Bits 7-5 of supply/clock and thermal shutdown registers
   localparam logic [1:0] RSVD2 = 2'h0;     // Bits 7-6 of warnings register

   // =============================================================
   // Channel state report codes
   localparam logic [1:0] CODE_PLAY = 2'h0;  // Playing
   localparam logic [1:0] CODE_HIZ  = 2'h1;  // High-impedance output
   localparam logic [1:0] CODE_MUTE = 2'h2;  // Muted
   localparam logic [1:0] CODE_DIAG = 2'h3;  // DC load diagnostic running

   // =============================================================
   // DC load diagnostic duration
   localparam int CLK_PERIOD_NS = 8;        // 125 MHz system clock
   localparam int DIAG_TIME_NS  = 10000;    // Least diagnostic run time
   localparam int DIAG_CYCLES   = (DIAG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIAG_CNT_W    = 11;       // Holds DIAG_CYCLES - 1
   localparam logic [DIAG_CNT_W-1:0] DIAG_LOAD = DIAG_CNT_W'(DIAG_CYCLES - 1);
   localparam logic [DIAG_CNT_W-1:0] DIAG_ZERO = '0;
   localparam logic [DIAG_CNT_W-1:0] DIAG_STEP = DIAG_CNT_W'(1);

endpackage

/* rtl/amp_chan_seq.sv */
`timescale 1ns/10ps
// =============================================================
// One channel: operating state and DC load diagnostic sequencer
module amp_chan_seq
   import amp_status_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       hiz_req,           // Channel asked to be high-impedance
   input  wire logic       mute_req,          // Channel asked to be muted
   input  wire logic       fault_evt,         // Overcurrent or DC fault this cycle
   input  wire logic       auto_diag_skip,    // No automatic diagnostics
   input  wire logic       line_out_diag_en,  // Line-output detection allowed
   input  wire logic [3:0] meas_flags,        // Ground, supply, open, shorted results
   input  wire logic       meas_line_out,     // Line-level load seen
   output logic [1:0]      state_code,        // Reported state
   output logic [3:0]      diag_flags,        // Latched diagnostic results
   output logic            line_out_found     // Latched line-output result
);

   typedef enum logic [1:0] {S_HIZ, S_PLAY, S_MUTE, S_DIAG} seq_state_t;

   typedef struct packed {
      seq_state_t            st;          // Sequencer state
      logic [DIAG_CNT_W-1:0] cnt;         // Cycles left in diagnostic
      logic [1:0]            code;        // Reported state code
      logic [3:0]            flags;       // Diagnostic flags
      logic                  line_out;    // Line-output flag
   } chan_t;

   localparam chan_t CHAN_RST = '{S_HIZ, DIAG_ZERO, CODE_HIZ, 4'h0, 1'b0};

   chan_t cur;                            // Registered state
   chan_t next_cur;                       // Next state

   // Report code of a sequencer state
   function automatic logic [1:0] code_of(input seq_state_t s);
      case (s)
         S_PLAY:  code_of = CODE_PLAY;
         S_MUTE:  code_of = CODE_MUTE;
         S_DIAG:  code_of = CODE_DIAG;
         default: code_of = CODE_HIZ;
      endcase
   endfunction

   // Next state of the channel
   always_comb begin
      next_cur = cur;
      case (cur.st)
         S_HIZ: begin
            if (!hiz_req) begin
               if (!auto_diag_skip) begin
                  next_cur.st  = S_DIAG;
                  next_cur.cnt = DIAG_LOAD;
               end else begin
                  next_cur.st = mute_req ? S_MUTE : S_PLAY;
               end
            end
         end
         S_PLAY, S_MUTE: begin
            if (hiz_req) begin
               next_cur.st = S_HIZ;
            end else if (fault_evt) begin
               if (!auto_diag_skip) begin
                  next_cur.st  = S_DIAG;
                  next_cur.cnt = DIAG_LOAD;
               end else begin
                  next_cur.st = S_HIZ;
               end
            end else begin
               next_cur.st = mute_req ? S_MUTE : S_PLAY;
            end
         end
         S_DIAG: begin
            if (cur.cnt == DIAG_ZERO) begin
               next_cur.flags = meas_flags;
               if (line_out_diag_en) begin
                  next_cur.line_out = meas_line_out;
               end
               next_cur.st = hiz_req ? S_HIZ : (mute_req ? S_MUTE : S_PLAY);
            end else begin
               next_cur.cnt = cur.cnt - DIAG_STEP;
            end
         end
         default: next_cur.st = S_HIZ;
      endcase
      // Detection result stays clear while disabled
      if (!line_out_diag_en) begin
         next_cur.line_out = 1'b0;
      end
      next_cur.code = code_of(next_cur.st);
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cur <= CHAN_RST;
      end else begin
         cur <= next_cur;
      end
   end

   assign state_code     = cur.code;
   assign diag_flags     = cur.flags;
   assign line_out_found = cur.line_out;

   // =============================================================
   // Checks
   sequence s_diag_hold;
      (state_code == CODE_DIAG) [*8];
   endsequence

   property p_diag_entry;
      @(posedge sys_clk) disable iff (rst)
      (state_code == CODE_HIZ && !hiz_req && !auto_diag_skip) |=> s_diag_hold;
   endproperty
   a_diag_entry: assert property (p_diag_entry) else $error("diagnostic not started");

   logic [DIAG_CNT_W-1:0] diag_age;     // Cycles the diagnostic code has stood

   // Counts diagnostic cycles; a stuck sequencer runs past the load value
   always_ff @(posedge sys_clk) begin
      if (rst || state_code != CODE_DIAG) begin
         diag_age <= DIAG_ZERO;
      end else begin
         diag_age <= diag_age + DIAG_STEP;
      end
   end

   property p_diag_bound;
      @(posedge sys_clk) disable iff (rst)
      (state_code == CODE_DIAG) |-> (diag_age <= DIAG_LOAD);
   endproperty
   a_diag_bound: assert property (p_diag_bound) else $error("diagnostic never ends");

   property p_line_out_clear;
      @(posedge sys_clk) disable iff (rst)
      !line_out_diag_en |=> !line_out_found;
   endproperty
   a_line_out_clear: assert property (p_line_out_clear) else $error("line flag while off");

   property p_reset_hiz;
      @(posedge sys_clk) disable iff (rst)
      $past(rst) |-> (state_code == CODE_HIZ && diag_flags == 4'h0);
   endproperty
   a_reset_hiz: assert property (p_reset_hiz) else $error("bad state after reset");

endmodule

/* rtl/amp_diag_fault_status_bank.sv */
`timescale 1ns/10ps
// =============================================================
// Read-only status bank: diagnostics, channel state, faults, warnings

module amp_diag_fault_status_bank
   import amp_status_pkg::*;
(
   input  wire logic              sys_clk,               // System clock, 125 MHz
   input  wire logic              rst,                   // Synchronous reset, high
   input  wire logic [7:0]        reg_addr,              // Register offset
   input  wire logic              reg_rd,                // Read strobe
   input  wire logic              reg_wr,                // Write strobe
   output logic [REG_W-1:0]       rd_data,               // Read data
   output logic                   rd_valid,              // Read data valid
   output logic                   wr_refused,            // Write to bank dropped
   input  wire logic [NUM_CH-1:0] hiz_req,               // Per-channel Hi-Z request
   input  wire logic [NUM_CH-1:0] mute_req,              // Per-channel mute request
   input  wire logic              auto_diag_skip,        // Bypass auto diagnostics
   input  wire logic              line_out_diag_en,      // Enable line-output detection
   input  wire logic              overcurrent_pin_mask,  // Keep overcurrent off the pin
   input  wire logic [NUM_CH-1:0] meas_short_to_ground,  // Diagnostic comparators
   input  wire logic [NUM_CH-1:0] meas_short_to_supply,
   input  wire logic [NUM_CH-1:0] meas_open_load,
   input  wire logic [NUM_CH-1:0] meas_shorted_load,
   input  wire logic [NUM_CH-1:0] meas_line_out,
   input  wire logic [NUM_CH-1:0] overcurrent_evt,       // Overcurrent events
   input  wire logic [NUM_CH-1:0] dc_offset_evt,         // DC offset events
   input  wire logic              clock_invalid,         // Input clock invalid, level
   input  wire logic              power_stage_overvolt,  // Supply monitors, levels
   input  wire logic              battery_overvolt,
   input  wire logic              power_stage_undervolt,
   input  wire logic              battery_undervolt,
   input  wire logic              thermal_shutdown,      // Global shutdown, level
   input  wire logic [NUM_CH-1:0] thermal_shutdown_ch,   // Channel shutdowns, levels
   input  wire logic              thermal_warning,       // Global warning, level
   input  wire logic [NUM_CH-1:0] thermal_warning_ch,    // Channel warnings, levels
   input  wire logic              vdd_por_evt,           // Logic supply power-on event
   output logic                   fault_pin_n            // Fault pin, low active
);

   // =============================================================
   // Bank state
   typedef struct packed {
      logic [REG_W-1:0]  rdata;         // Read data register
      logic              rvalid;        // Read answer strobe
      logic              wrefused;      // Write refused strobe
      logic [NUM_CH-1:0] oc;            // Sticky overcurrent flags
      logic [NUM_CH-1:0] dc;            // Sticky DC offset flags
      logic [4:0]        supply;        // Clock and supply faults
      logic              tsd;           // Global thermal shutdown
      logic [NUM_CH-1:0] tsd_ch;        // Channel thermal shutdowns
      logic              por;           // Power-on flag
      logic              tw;            // Global thermal warning
      logic [NUM_CH-1:0] tw_ch;         // Channel thermal warnings
      logic              fault_n;       // Fault pin level
   } bank_t;

   localparam bank_t BANK_RST = '{
      rdata:    READ_ZERO,
      rvalid:   1'b0,
      wrefused: 1'b0,
      oc:       RST_CHANNEL_FAULT[7:4],
      dc:       RST_CHANNEL_FAULT[3:0],
      supply:   5'h00,
      tsd:      1'b0,
      tsd_ch:   4'h0,
      por:      RST_WARNINGS[5],
      tw:       1'b0,
      tw_ch:    4'h0,
      fault_n:  1'b1
   };

   bank_t cur;                          // Registered bank state
   bank_t next_cur;                     // Next bank state

   // Per-channel sequencer outputs
   logic [1:0]        ch_state [NUM_CH];   // State codes
   logic [3:0]        ch_diag  [NUM_CH];   // Diagnostic flags
   logic [NUM_CH-1:0] ch_line;             // Line-output flags

   // Read-side helpers
   logic              rd_fault;            // Read of channel fault register
   logic              rd_warn;             // Read of warnings register

   // =============================================================
   // Helper functions

   // Channel 1 goes to the highest bit of a four-bit field
   function automatic logic [3:0] pack_ch(input logic [NUM_CH-1:0] v);
      pack_ch = {v[0], v[1], v[2], v[3]};
   endfunction

   // Offset lies inside this bank
   function automatic logic in_bank(input logic [7:0] a);
      in_bank = (a >= OFF_DC_DIAG_B) && (a <= OFF_WARNINGS);
   endfunction

   // Four channel state codes, channel 1 first
   function automatic logic [REG_W-1:0] pack_state(input logic [1:0] s0,
                                                   input logic [1:0] s1,
                                                   input logic [1:0] s2,
                                                   input logic [1:0] s3);
      pack_state = {s0, s1, s2, s3};
   endfunction

   // =============================================================
   // Channel sequencers
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
         // Each channel runs its own state and diagnostic timing
         amp_chan_seq u_seq (
            .sys_clk          (sys_clk),
            .rst              (rst),
            .hiz_req          (hiz_req[gi]),
            .mute_req         (mute_req[gi]),
            .fault_evt        (overcurrent_evt[gi] | dc_offset_evt[gi]),
            .auto_diag_skip   (auto_diag_skip),
            .line_out_diag_en (line_out_diag_en),
            .meas_flags       ({meas_short_to_ground[gi], meas_short_to_supply[gi],
                                meas_open_load[gi], meas_shorted_load[gi]}),
            .meas_line_out    (meas_line_out[gi]),
            .state_code       (ch_state[gi]),
            .diag_flags       (ch_diag[gi]),
            .line_out_found   (ch_line[gi])
         );
      end
   endgenerate

   // =============================================================
   // Read decode
   always_comb begin
      rd_fault = reg_rd && (reg_addr == OFF_CHANNEL_FAULT);  // Clears fault flags
      rd_warn  = reg_rd && (reg_addr == OFF_WARNINGS);       // Clears power-on flag
   end

   // Next bank state
   always_comb begin
      next_cur = cur;
      next_cur.rvalid   = reg_rd;
      // Writes never touch the bank; they are only reported
      next_cur.wrefused = reg_wr && in_bank(reg_addr);

      // Read data multiplexer
      if (reg_rd) begin
         case (reg_addr)
            OFF_DC_DIAG_B:
               next_cur.rdata = {ch_diag[2], ch_diag[3]};
            OFF_LINE_OUT:
               next_cur.rdata = {RSVD4, pack_ch(ch_line)};
            OFF_CHANNEL_STATE:
               next_cur.rdata = pack_state(ch_state[0], ch_state[1],
                                           ch_state[2], ch_state[3]);
            OFF_CHANNEL_FAULT:
               next_cur.rdata = {pack_ch(cur.oc), pack_ch(cur.dc)};
            OFF_SUPPLY_CLOCK:
               next_cur.rdata = {RSVD3, cur.supply};
            OFF_THERMAL_SD:
               next_cur.rdata = {RSVD3, cur.tsd, pack_ch(cur.tsd_ch)};
            OFF_WARNINGS:
               next_cur.rdata = {RSVD2, cur.por, cur.tw, pack_ch(cur.tw_ch)};
            default:
               next_cur.rdata = READ_ZERO;                       // Unmapped offset
         endcase
      end

      // Sticky fault flags: a new event wins over the clear by read
      next_cur.oc = (cur.oc & ~{NUM_CH{rd_fault}}) | overcurrent_evt;
      next_cur.dc = (cur.dc & ~{NUM_CH{rd_fault}}) | dc_offset_evt;

      // Live supply and clock status
      next_cur.supply = {clock_invalid, power_stage_overvolt,
                         battery_overvolt, power_stage_undervolt,
                         battery_undervolt};

      // Live thermal status
      next_cur.tsd    = thermal_shutdown;
      next_cur.tsd_ch = thermal_shutdown_ch;
      next_cur.tw     = thermal_warning;
      next_cur.tw_ch  = thermal_warning_ch;

      // Power-on flag: set by power-on, kept until read
      next_cur.por = (cur.por & ~rd_warn) | vdd_por_evt;

      // Fault pin follows any overcurrent flag unless masked
      next_cur.fault_n = ~((|cur.oc) & ~overcurrent_pin_mask);
   end

   // Bank register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cur <= BANK_RST;
      end else begin
         cur <= next_cur;
      end
   end

   // Outputs straight from the bank register
   assign rd_data     = cur.rdata;
   assign rd_valid    = cur.rvalid;
   assign wr_refused  = cur.wrefused;
   assign fault_pin_n = cur.fault_n;

   // =============================================================
   // Checks
   sequence s_read_of(logic [7:0] off);
      reg_rd && (reg_addr == off);
   endsequence

   property p_state_read;
      @(posedge sys_clk) disable iff (rst)
      s_read_of(OFF_CHANNEL_STATE) |=>
         rd_valid && (rd_data == pack_state($past(ch_state[0]), $past(ch_state[1]),
                                            $past(ch_state[2]), $past(ch_state[3])));
   endproperty
   a_state_read: assert property (p_state_read) else $error("state read mismatch");

   property p_line_rsvd;
      @(posedge sys_clk) disable iff (rst)
      s_read_of(OFF_LINE_OUT) |=> rd_valid && (rd_data[7:4] == RSVD4);
   endproperty
   a_line_rsvd: assert property (p_line_rsvd) else $error("reserved bits set");

   property p_oc_set_wins;
      @(posedge sys_clk) disable iff (rst)
      (s_read_of(OFF_CHANNEL_FAULT) and overcurrent_evt[0]) |=>
         ##1 ($past(overcurrent_pin_mask) || !fault_pin_n);
   endproperty
   a_oc_set_wins: assert property (p_oc_set_wins) else $error("clear beat overcurrent");

   property p_oc_sticky;
      @(posedge sys_clk) disable iff (rst)
      overcurrent_evt[0] ##1 (!reg_rd)
         |=> reg_rd && reg_addr == OFF_CHANNEL_FAULT |=> rd_data[7];
   endproperty
   a_oc_sticky: assert property (p_oc_sticky) else $error("overcurrent flag lost");

   property p_oc_evt_read;
      @(posedge sys_clk) disable iff (rst)
      (s_read_of(OFF_CHANNEL_FAULT) and overcurrent_evt[0]) ##1 !reg_rd
         ##1 s_read_of(OFF_CHANNEL_FAULT) |=> rd_data[7];
   endproperty
   a_oc_evt_read: assert property (p_oc_evt_read) else $error("set lost to clear");

   property p_fault_pin;
      @(posedge sys_clk) disable iff (rst)
      (overcurrent_evt != 4'h0 && !overcurrent_pin_mask) ##1 !overcurrent_pin_mask
         |=> !fault_pin_n;
   endproperty
   a_fault_pin: assert property (p_fault_pin) else $error("fault pin not driven");

   property p_fault_masked;
      @(posedge sys_clk) disable iff (rst)
      overcurrent_pin_mask |=> fault_pin_n;
   endproperty
   a_fault_masked: assert property (p_fault_masked) else $error("masked fault on pin");

   property p_por_after_reset;
      @(posedge sys_clk) disable iff (rst)
      ($past(rst) || ($past(rst, 2) && !$past(rd_warn))) ##0 s_read_of(OFF_WARNINGS)
         |=> rd_data[5];
   endproperty
   a_por_after_reset: assert property (p_por_after_reset) else $error("power-on flag clear");

   property p_write_ignored;
      @(posedge sys_clk) disable iff (rst)
      (reg_wr && !reg_rd && in_bank(reg_addr)) |=> wr_refused && !rd_valid;
   endproperty
   a_write_ignored: assert property (p_write_ignored) else $error("write not refused");

   property p_clock_fault;
      @(posedge sys_clk) disable iff (rst)
      clock_invalid ##1 (s_read_of(OFF_SUPPLY_CLOCK) and clock_invalid) |=> rd_data[4];
   endproperty
   a_clock_fault: assert property (p_clock_fault) else $error("clock fault not shown");

   property p_dc_diag_read;
      @(posedge sys_clk) disable iff (rst)
      s_read_of(OFF_DC_DIAG_B) |=>
         rd_valid && (rd_data == {$past(ch_diag[2]), $past(ch_diag[3])});
   endproperty
   a_dc_diag_read: assert property (p_dc_diag_read) else $error("diag read mismatch");

   property p_supply_rsvd;
      @(posedge sys_clk) disable iff (rst)
      s_read_of(OFF_SUPPLY_CLOCK) |=> (rd_data[7:5] == RSVD3);
   endproperty
   a_supply_rsvd: assert property (p_supply_rsvd) else $error("reserved bits set");

   property p_supply_read;
      @(posedge sys_clk) disable iff (rst)
      power_stage_overvolt ##1 s_read_of(OFF_SUPPLY_CLOCK) |=> rd_data[3];
   endproperty
   a_supply_read: assert property (p_supply_read) else $error("overvolt not shown");

   property p_thermal_rsvd;
      @(posedge sys_clk) disable iff (rst)
      s_read_of(OFF_THERMAL_SD) |=> (rd_data[7:5] == RSVD3);
   endproperty
   a_thermal_rsvd: assert property (p_thermal_rsvd) else $error("reserved bits set");

   property p_thermal_live;
      @(posedge sys_clk) disable iff (rst)
      thermal_shutdown ##1 s_read_of(OFF_THERMAL_SD) |=> rd_data[4];
   endproperty
   a_thermal_live: assert property (p_thermal_live) else $error("shutdown not shown");

   property p_warn_rsvd;
      @(posedge sys_clk) disable iff (rst)
      s_read_of(OFF_WARNINGS) |=> (rd_data[7:6] == RSVD2);
   endproperty
   a_warn_rsvd: assert property (p_warn_rsvd) else $error("reserved bits set");

   property p_warn_live;
      @(posedge sys_clk) disable iff (rst)
      thermal_warning ##1 s_read_of(OFF_WARNINGS) |=> rd_data[4];
   endproperty
   a_warn_live: assert property (p_warn_live) else $error("warning not shown");

   property p_line_clear_read;
      @(posedge sys_clk) disable iff (rst)
      !line_out_diag_en ##1 s_read_of(OFF_LINE_OUT) |=> (rd_data[3:0] == 4'h0);
   endproperty
   a_line_clear_read: assert property (p_line_clear_read) else $error("line bit while off");

endmodule

/* tb/host_model.sv */
`timescale 1ns/10ps
// ==========================================
// Host side of the register port, one request per call
module host_model (
   input  wire logic       sys_clk,     // System clock
   input  wire logic [7:0] rd_data,     // Read data from the bank
   input  wire logic       rd_valid,    // Read answer strobe
   input  wire logic       wr_refused,  // Write answer strobe
   output logic      [7:0] reg_addr,    // Register offset
   output logic            reg_rd,      // Read strobe
   output logic            reg_wr       // Write strobe
);
   // Idle levels from time zero
   initial begin
      reg_addr = 8'h00;
      reg_rd   = 1'b0;
      reg_wr   = 1'b0;
   end
   // Read: one-cycle strobe, answer sampled one cycle later
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge sys_clk) #1;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge sys_clk) #1;
      reg_rd   = 1'b0;
      reg_addr = ~a;    // Released offset no longer shows the old value
      v        = rd_valid;
      d        = rd_data;
   endtask
   // Write: no data is carried, the bank should refuse it
   task automatic wr(input logic [7:0] a, output logic v);
      @(posedge sys_clk) #1;
      reg_addr = a;
      reg_wr   = 1'b1;
      @(posedge sys_clk) #1;
      reg_wr   = 1'b0;
      reg_addr = ~a;
      v        = wr_refused;
   endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/10ps
// ==========================================
// Bench for the status register bank
module tb;
   logic       sys_clk, rst, skip, len, msk, ci, pov, bov, puv, buv, ts, tw, por;
   logic [3:0] hiz, mute, g, s, o, sl, lo, oc, dc, tsc, twc;
   logic [7:0] addr, d;
   logic       rd, wr, rv, wref, pin_n, v;
   int         n_mismatch = 0;
   int         num_checks = 0;
   amp_diag_fault_status_bank i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(addr),
      .reg_rd(rd), .reg_wr(wr), .rd_data(d), .rd_valid(rv), .wr_refused(wref),
      .hiz_req(hiz), .mute_req(mute), .auto_diag_skip(skip), .line_out_diag_en(len),
      .overcurrent_pin_mask(msk), .meas_short_to_ground(g), .meas_short_to_supply(s),
      .meas_open_load(o), .meas_shorted_load(sl), .meas_line_out(lo),
      .overcurrent_evt(oc), .dc_offset_evt(dc), .clock_invalid(ci),
      .power_stage_overvolt(pov), .battery_overvolt(bov), .power_stage_undervolt(puv),
      .battery_undervolt(buv), .thermal_shutdown(ts), .thermal_shutdown_ch(tsc),
      .thermal_warning(tw), .thermal_warning_ch(twc), .vdd_por_evt(por),
      .fault_pin_n(pin_n));
   host_model i_host (.sys_clk(sys_clk), .rd_data(d), .rd_valid(rv), .wr_refused(wref),
      .reg_addr(addr), .reg_rd(rd), .reg_wr(wr));
   // ==========================================
   // Shared tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] x;
      i_host.rd(a, x, v);
      chk1(v, 1'b1);
      chk8(x, e);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_write;
      i_host.wr(8'h0F, v);
      chk1(v, 1'b1);
      rchk(8'h0F, 8'h55);
   endtask
   task automatic t_live;
      {ci, pov, bov, puv, buv, ts, tw, por} = 8'hFF;
      tsc = 4'h9;
      twc = 4'h6;
      cyc(1);
      por = 1'b0;
      cyc(1);
      rchk(8'h11, 8'h1F);
      rchk(8'h12, 8'h19);
      rchk(8'h13, 8'h36);
      {ci, pov, bov, puv, buv, ts, tw, tsc, twc} = 15'h0000;
      cyc(2);
      rchk(8'h11, 8'h00);
      rchk(8'h13, 8'h00);
   endtask
   task automatic t_fault;
      oc = 4'h1;
      dc = 4'h8;
      cyc(1);
      {oc, dc} = 8'h00;
      cyc(2);
      chk1(pin_n, 1'b0);
      rchk(8'h10, 8'h81);
      rchk(8'h10, 8'h00);
      cyc(2);
      chk1(pin_n, 1'b1);
      {msk, oc} = 5'h11;
      cyc(1);
      oc = 4'h0;
      cyc(2);
      chk1(pin_n, 1'b1);
      msk = 1'b0;
      cyc(2);
      chk1(pin_n, 1'b0);
      oc = 4'h1;
      rchk(8'h10, 8'h80);
      oc = 4'h0;
      rchk(8'h10, 8'h80);
      rchk(8'h10, 8'h00);
   endtask
   task automatic t_diag;
      {len, g, o, lo, hiz} = 17'h1_444B;
      cyc(2);
      rchk(8'h0F, 8'h5D);
      cyc(1300);
      rchk(8'h0D, 8'hA0);
      rchk(8'h0E, 8'h02);
      rchk(8'h0F, 8'h51);
      mute = 4'h4;
      cyc(2);
      rchk(8'h0F, 8'h59);
      len = 1'b0;
      cyc(2);
      rchk(8'h0E, 8'h00);
      dc = 4'h4;
      cyc(1);
      dc = 4'h0;
      cyc(1);
      rchk(8'h0F, 8'h5D);
      {skip, hiz} = 5'h13;
      cyc(2);
      rchk(8'h0F, 8'h5C);
   endtask
   task automatic t_reset;
      {rst, hiz, skip} = 6'h3E;
      cyc(2);
      rst = 1'b0;
      rchk(8'h13, 8'h20);
      rchk(8'h0F, 8'h55);
      rchk(8'h10, 8'h00);
   endtask
   // ==========================================
   // Clock, reset and main sequence
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      {rst, skip, len, msk, ci, pov, bov, puv, buv, ts, tw, por} = 12'h800;
      {hiz, mute, g, s, o, sl, lo, oc, dc, tsc, twc} = 44'hF00_0000_0000;
      repeat (6) @(posedge sys_clk);
      #1 rst = 1'b0;
      for (int i = 0; i < 8; i++) begin
         rchk(8'h0D + 8'(i), (i == 2) ? 8'h55 : (i == 6) ? 8'h20 : 8'h00);
      end
      t_write();
      t_live();
      t_fault();
      t_diag();
      t_reset();
      tally_and_finish();
   end
endmodule
